/* core/svxr_pkg.sv */
// package for the secure virtual translation request/result register bank
package svxr_pkg;
  localparam logic [11:0] SVXR_OFF_CTRL   = 12'hA00;
  localparam logic [11:0] SVXR_OFF_ADDR   = 12'hA10;
  localparam logic [11:0] SVXR_OFF_RESULT = 12'hA18;
  localparam int          SVXR_RUN_BIT    = 0;
  localparam logic [1:0]  SVXR_TYPE_S1    = 2'h1;
  localparam logic [1:0]  SVXR_SH_OUTER   = 2'h2;
  localparam logic [7:0]  SVXR_FC_INVALID_REQUEST_ERROR = 8'h01;
  localparam int          SVXR_ADDR_TYPE_LO = 10;
  localparam int          SVXR_ADDR_RNW   = 8;
  localparam int          SVXR_ADDR_IND   = 7;
  localparam logic [63:0] SVXR_ADDR_RES0  = 64'h0000_0000_0000_003F;
  typedef struct packed {
    logic        valid;
    logic        fault;
    logic [7:0]  memory_attribute_byte;
    logic [39:0] oaddr;
    logic        size_flag;
    logic        sec_memory_attribute_byte;
    logic [1:0]  share;
    logic        device_mem;
    logic [7:0]  fault_code;
    logic [3:0]  impdef;
  } svxr_resp_s;
  typedef struct packed {
    logic        req;
    logic [39:0] in_addr;
    logic        read_not_write;
    logic        instr_not_data;
    logic        privileged;
    logic        no_flag_update;
  } svxr_walk_s;
endpackage

/* core/svxr_regs.sv */
// secure virtual translation request address, run flag and result registers
`timescale 1ns/1ns
module svxr_regs (
  input  wire logic               clk,
  input  wire logic               reset_n,
  input  wire logic               feature_present,
  input  wire logic               reg_sel,
  input  wire logic               reg_wr,
  input  wire logic               reg_secure,
  input  wire logic [11:0]        reg_addr,
  input  wire logic [63:0]        reg_wdata,
  input  wire svxr_pkg::svxr_resp_s walk_resp,
  output logic      [63:0]        reg_rdata,
  output logic                    run_flag,
  output svxr_pkg::svxr_walk_s    walk_req
);
  typedef enum logic [1:0] {
    SVXR_IDLE = 2'b01,
    SVXR_BUSY = 2'b10
  } svxr_state_e;

  svxr_state_e          state_r;
  svxr_state_e          state_nxt;
  logic                 run_r;
  logic                 run_nxt;
  logic [63:0]          addr_r;
  logic [63:0]          addr_nxt;
  logic [63:0]          result_r;
  logic [63:0]          result_nxt;
  logic [63:0]          rdata_r;
  logic [63:0]          rdata_nxt;
  svxr_pkg::svxr_walk_s walk_r;
  svxr_pkg::svxr_walk_s walk_nxt;
  logic                 acc_ok;
  logic                 busy;
  logic                 type_ok;
  logic                 wr_addr;
  logic                 wr_go;
  logic                 rd_addr;
  logic                 rd_result;
  logic                 rd_ctrl;
  logic                 done_bad;
  logic                 done_ok;

  // shared by every read and write decoder below
  function automatic logic hit(input logic [11:0] a, input logic [11:0] off);
    hit = reg_sel && (a == off);
  endfunction

  // success layout; device memory always reports outer shareable
  function automatic logic [63:0] pack_ok(input svxr_pkg::svxr_resp_s r);
    logic [1:0] sh;
    sh      = r.device_mem ? svxr_pkg::SVXR_SH_OUTER : r.share;
    pack_ok = {1'b0, r.memory_attribute_byte, 4'h0, r.oaddr,
               r.size_flag, r.sec_memory_attribute_byte, sh, 7'h0};
  endfunction

  // fault layout; page address, intermediate security bit and class stay zero
  function automatic logic [63:0] pack_fault(input logic [7:0] code,
                                             input logic [3:0] imp);
    pack_fault = {1'b0, imp, 8'h0, 40'h0,
                  code, 1'b0, 1'b0, 1'b1};
  endfunction

  // non-secure or absent feature: reads zero, writes dropped
  assign acc_ok    = reg_secure && feature_present;
  assign busy      = (state_r == SVXR_BUSY);
  assign type_ok   = (addr_r[11:10] == svxr_pkg::SVXR_TYPE_S1);
  assign wr_addr   = acc_ok && reg_wr && hit(reg_addr, svxr_pkg::SVXR_OFF_ADDR);
  assign wr_go     = acc_ok && reg_wr && hit(reg_addr, svxr_pkg::SVXR_OFF_CTRL) &&
                     reg_wdata[svxr_pkg::SVXR_RUN_BIT];
  assign rd_addr   = acc_ok && !reg_wr && hit(reg_addr, svxr_pkg::SVXR_OFF_ADDR);
  assign rd_result = acc_ok && !reg_wr && hit(reg_addr, svxr_pkg::SVXR_OFF_RESULT);
  assign rd_ctrl   = acc_ok && !reg_wr && hit(reg_addr, svxr_pkg::SVXR_OFF_CTRL);
  assign done_bad  = busy && !type_ok;
  assign done_ok   = busy && type_ok && walk_resp.valid;

  // run flag kept in its own flop so the output carries no decode
  always_comb begin
    state_nxt = state_r;
    run_nxt   = run_r;
    case (state_r)
      SVXR_IDLE: begin
        if (wr_go) begin
          state_nxt = SVXR_BUSY;
          run_nxt   = 1'b1;
        end
      end
      SVXR_BUSY: begin
        // a run write while busy is ignored; answers while idle too
        if (done_bad || done_ok) begin
          state_nxt = SVXR_IDLE;
          run_nxt   = 1'b0;
        end
      end
      default: begin
        state_nxt = SVXR_IDLE;
        run_nxt   = 1'b0;
      end
    endcase
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state_r <= SVXR_IDLE;
      run_r   <= 1'b0;
    end else begin
      state_r <= state_nxt;
      run_r   <= run_nxt;
    end
  end

  always_comb begin
    addr_nxt = addr_r;
    // guarded by the busy state: writes while busy are dropped
    if (wr_addr && !busy) begin
      addr_nxt = reg_wdata & ~svxr_pkg::SVXR_ADDR_RES0;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      addr_r <= 64'h0;
    end else begin
      addr_r <= addr_nxt;
    end
  end

  always_comb begin
    result_nxt = result_r;
    // whole word replaced in the cycle the run clears
    if (done_bad) begin
      result_nxt = pack_fault(svxr_pkg::SVXR_FC_INVALID_REQUEST_ERROR, 4'h0);
    end else if (done_ok) begin
      if (walk_resp.fault) begin
        result_nxt = pack_fault(walk_resp.fault_code, walk_resp.impdef);
      end else begin
        result_nxt = pack_ok(walk_resp);
      end
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      result_r <= 64'h0;
    end else begin
      result_r <= result_nxt;
    end
  end

  always_comb begin
    rdata_nxt = 64'h0;
    if (rd_addr) begin
      rdata_nxt = addr_r;
    end else if (rd_result) begin
      // read during a run shows the previous result
      rdata_nxt = result_r;
    end else if (rd_ctrl) begin
      rdata_nxt = {63'h0, run_r};
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rdata_r <= 64'h0;
    end else begin
      rdata_r <= rdata_nxt;
    end
  end

  always_comb begin
    walk_nxt     = walk_r;
    walk_nxt.req = 1'b0;
    // a reserved type never reaches the walker
    if (!busy && wr_go && type_ok) begin
      walk_nxt.req            = 1'b1;
      walk_nxt.in_addr        = addr_r[51:12];
      walk_nxt.read_not_write = addr_r[svxr_pkg::SVXR_ADDR_RNW];
      // writes are always data accesses
      walk_nxt.instr_not_data = addr_r[svxr_pkg::SVXR_ADDR_RNW] &
                                addr_r[svxr_pkg::SVXR_ADDR_IND];
      walk_nxt.privileged     = addr_r[9];
      walk_nxt.no_flag_update = addr_r[6];
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      walk_r <= '0;
    end else begin
      walk_r <= walk_nxt;
    end
  end

  assign reg_rdata = rdata_r;
  assign run_flag  = run_r;
  assign walk_req  = walk_r;
endmodule

/* dv/svxr_regs_asserts.sv */
// checker for the secure translation register bank
`timescale 1ns/1ns
module svxr_regs_chk (
  input wire logic                 clk,
  input wire logic                 reset_n,
  input wire logic                 feature_present,
  input wire logic                 reg_sel,
  input wire logic                 reg_wr,
  input wire logic                 reg_secure,
  input wire logic [11:0]          reg_addr,
  input wire logic [63:0]          reg_wdata,
  input wire svxr_pkg::svxr_resp_s walk_resp,
  input wire logic [63:0]          reg_rdata,
  input wire logic                 run_flag,
  input wire svxr_pkg::svxr_walk_s walk_req
);
  logic ok, rd_res;
  assign ok = reg_sel && reg_secure && feature_present;
  assign rd_res = ok && !reg_wr && reg_addr == svxr_pkg::SVXR_OFF_RESULT;
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  run_go_a: assert property (ok && reg_wr && reg_addr == svxr_pkg::SVXR_OFF_CTRL
    && reg_wdata[0] && !run_flag |=> run_flag) else $error("run not started");
  run_done_a: assert property (run_flag && walk_resp.valid |=> !run_flag) else $error("run stuck");
  ns_zero_a: assert property (reg_sel && !reg_wr && !reg_secure |=> reg_rdata == 0) else $error("ns read");
  absent_zero_a: assert property (reg_sel && !reg_wr && !feature_present |=> reg_rdata == 0)
    else $error("absent read");
  req_pulse_a: assert property (walk_req.req |=> !walk_req.req) else $error("req too long");
  write_data_a: assert property (walk_req.req && !walk_req.read_not_write
    |-> !walk_req.instr_not_data) else $error("write as instr");
  ok_format_a: assert property (rd_res ##1 !reg_rdata[0]
    |-> reg_rdata[54:51] == 0 && reg_rdata[6:1] == 0) else $error("success layout");
  fault_format_a: assert property (rd_res ##1 reg_rdata[0]
    |-> reg_rdata[58:11] == 0 && reg_rdata[2:1] == 0) else $error("fault layout");
  cover property (rd_res ##1 reg_rdata[0]);
  cover property (run_flag && walk_resp.valid);
  cover property (reg_sel && !reg_secure);
endmodule
bind svxr_regs svxr_regs_chk chk (.clk, .reset_n, .feature_present, .reg_sel, .reg_wr,
  .reg_secure, .reg_addr, .reg_wdata, .walk_resp, .reg_rdata, .run_flag, .walk_req);

/* dv/tb.sv */
// self-checking bench for the secure translation register bank
`timescale 1ns/1ns
module tb;
  logic                 clk, reset_n, feature_present, reg_sel, reg_wr, reg_secure, run_flag;
  logic [11:0]          reg_addr;
  logic [63:0]          reg_wdata, reg_rdata, q;
  svxr_pkg::svxr_resp_s walk_resp;
  svxr_pkg::svxr_walk_s walk_req;
  int                   n_fail, tests_run;
  // type 01, write access with the instruction bit set
  localparam logic [63:0] ADDR_A = 64'h0000_0012_3456_7480;
  svxr_regs uut (.clk(clk), .reset_n(reset_n), .feature_present(feature_present),
    .reg_sel(reg_sel), .reg_wr(reg_wr), .reg_secure(reg_secure), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .walk_resp(walk_resp), .reg_rdata(reg_rdata),
    .run_flag(run_flag), .walk_req(walk_req));
  initial begin
    clk = 0;
    forever #25 clk = ~clk;
  end
  task results;
    $display("comparisons %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task chk(input logic [63:0] got, exp);
    tests_run++;
    if (got !== exp) begin
      n_fail++;
      $display("mismatch at %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // one strobe cycle; read data is taken while it stands
  task acc(input logic w, s, input logic [11:0] a, input logic [63:0] d);
    @(posedge clk) #1 reg_sel = 1;
    {reg_wr, reg_secure, reg_addr, reg_wdata} = {w, s, a, d};
    @(posedge clk) #1 q = reg_rdata;
    reg_sel = 0;
  endtask
  task wait_idle;
    int i;
    for (i = 0; i < 100 && run_flag !== 1'h0; i++) @(posedge clk);
    if (i == 100) begin
      n_fail++;
      results();
    end
  endtask
  task t_regs;
    acc(1, 1, svxr_pkg::SVXR_OFF_ADDR, ADDR_A);
    acc(0, 1, svxr_pkg::SVXR_OFF_ADDR, 0);
    chk(q, ADDR_A);
    acc(1, 0, svxr_pkg::SVXR_OFF_ADDR, 0);
    acc(0, 0, svxr_pkg::SVXR_OFF_ADDR, 0);
    chk(q, 0);
    acc(0, 1, svxr_pkg::SVXR_OFF_ADDR, 0);
    chk(q, ADDR_A);
    feature_present = 0;
    acc(0, 1, svxr_pkg::SVXR_OFF_RESULT, 0);
    chk(q, 0);
    feature_present = 1;
    $display("register access test done");
  endtask
  task t_walk(input logic dev);
    acc(1, 1, svxr_pkg::SVXR_OFF_CTRL, 1);
    chk(64'(run_flag), 64'h1);
    chk(64'({walk_req.req, walk_req.read_not_write, walk_req.instr_not_data}), 64'h4);
    chk(64'(walk_req.in_addr), 64'(ADDR_A[51:12]));
    acc(1, 1, svxr_pkg::SVXR_OFF_ADDR, 0);
    acc(0, 1, svxr_pkg::SVXR_OFF_ADDR, 0);
    chk(q, ADDR_A);
    walk_resp = '{valid:1'h1, memory_attribute_byte:8'hA5, oaddr:40'h123_4567, size_flag:1'h1, sec_memory_attribute_byte:1'h1,
      share:2'h3, device_mem:dev, default:'0};
    @(posedge clk) #1 walk_resp.valid = 0;
    wait_idle();
    acc(1, 1, svxr_pkg::SVXR_OFF_RESULT, 64'hF);
    acc(0, 1, svxr_pkg::SVXR_OFF_RESULT, 0);
    chk(q, {9'h0A5, 4'h0, 40'h123_4567, 2'h3, dev ? 2'h2 : 2'h3, 7'h0});
    acc(0, 0, svxr_pkg::SVXR_OFF_RESULT, 0);
    chk(q, 0);
    $display("translation walk test done");
  endtask
  task t_bad;
    acc(1, 1, svxr_pkg::SVXR_OFF_ADDR, ADDR_A ^ 64'h400);
    acc(1, 1, svxr_pkg::SVXR_OFF_CTRL, 1);
    chk(64'(walk_req.req), 64'h0);
    wait_idle();
    acc(0, 1, svxr_pkg::SVXR_OFF_RESULT, 0);
    chk(q & ~64'h7800_0000_0000_0000, 64'h9);
    $display("reserved type test done");
  endtask
  initial begin
    {feature_present, reg_sel, reg_wr, reg_secure, reset_n} = 5'h10;
    {reg_addr, reg_wdata, walk_resp} = '0;
    repeat (12) @(posedge clk);
    #1 reset_n = 1;
    t_regs();
    t_walk(0);
    t_walk(1);
    t_bad();
    results();
  end
endmodule
